//--- verilog/fp_format_and_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "fp_format_params.svh"
module fp_format_and_status (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic [3:0]                addr,
  input  wire logic [31:0]               wr_data,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  input  wire logic                      copy_cond_codes,
  output var  logic [31:0]               rd_data,
  output var  fp_format_pkg::cond_codes_t cpu_cond,
  output var  logic                      cpu_cond_valid,
  output var  logic                      exc_irq,
  output var  logic                      double_precision_sel,
  output var  logic                      long_integer_sel,
  output var  logic                      truncate_sel
);
  import fp_format_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [15:0]  fp_program_status;
  logic [63:0]  mem_word;
  logic [63:0]  result_word;
  exc_t         last_exc;
  fp_internal_t unpacked;
  fp_internal_t normed;
  logic [63:0]  next_result;
  logic         conv_fail;
  logic         undef_hit;
  logic         do_load;
  logic         do_neg;
  logic         do_store;
  logic         do_conv;

  assign do_load  = wr_en && addr == `ADDR_MEM_CTL && wr_data[`CTL_LOAD];
  assign do_neg   = wr_en && addr == `ADDR_MEM_CTL && wr_data[`CTL_NEG];
  assign do_store = wr_en && addr == `ADDR_MEM_CTL && wr_data[`CTL_STORE];
  assign do_conv  = wr_en && addr == `ADDR_MEM_CTL && wr_data[`CTL_CONV];

  ////////////////////////////////////////////////////////////////////////
  // Unpack a memory word into the internal form.
  always_comb begin
    unpacked.sign = mem_word[63];
    unpacked.exp  = mem_word[62:55];
    if (fp_program_status[`BIT_DOUBLE]) begin
      unpacked.frac = {2'b01, mem_word[54:0], 7'h00};
    end else begin
      unpacked.frac = {2'b01, mem_word[54:32], 39'h0};
    end
    if (unpacked.exp == 8'h00) begin
      unpacked.frac = 64'h0;
    end
    undef_hit = unpacked.exp == 8'h00 && unpacked.sign;
    if (undef_hit && !fp_program_status[`BIT_UNDEF_EN]) begin
      unpacked.sign = 1'b0;
    end
  end

  // A load cannot set the overflow position, since unpacking always places 2'b01
  // above the fraction (or clears it); single step suffices here.
  always_comb begin
    normed = unpacked;
    if (unpacked.frac[`OVF_POS]) begin
      normed.frac = {1'b0, unpacked.frac[63:1]};
      normed.exp  = unpacked.exp + 8'h01;
    end
    if (do_neg) begin
      normed.sign = ~unpacked.sign;
    end
    next_result = {normed.sign, normed.exp, normed.frac[61:7]};
    if (!fp_program_status[`BIT_DOUBLE]) begin
      next_result[31:0] = 32'h0;
    end
    // round unless truncating
    // Rounding carry into the exponent is left to the arithmetic core.
    if (!fp_program_status[`BIT_TRUNC]) begin
      if (fp_program_status[`BIT_DOUBLE]) begin
        if (normed.frac[6]) begin
          next_result[54:0] = next_result[54:0] + 55'h1;
        end
      end else if (normed.frac[38]) begin
        next_result[54:32] = next_result[54:32] + 23'h1;
      end
    end
  end

  always_comb begin
    logic [7:0] limit;
    limit = fp_program_status[`BIT_LONG] ? 8'hA0 : 8'h90;
    conv_fail = unpacked.exp > limit;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_word <= 64'h0;
    end else if (wr_en && addr == `ADDR_MEM_HI) begin
      mem_word[63:32] <= wr_data;
    end else if (wr_en && addr == `ADDR_MEM_LO) begin
      mem_word[31:0] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_word <= 64'h0;
    end else if (do_conv && conv_fail) begin
      result_word <= 64'h0;
    end else if (do_load || do_neg || do_store) begin
      result_word <= next_result;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fp_program_status <= `STATUS_RESET;
      last_exc          <= EXC_NONE;
    end else begin
      if (wr_en && addr == `ADDR_STATUS) begin
        fp_program_status <= wr_data[15:0] & `STATUS_WMASK;
      end
      if (do_conv && conv_fail) begin
        fp_program_status[0]        <= 1'b1;
        fp_program_status[`BIT_ERR] <= 1'b1;
        last_exc                    <= EXC_CONV;
      end else if (do_load && undef_hit
                   && fp_program_status[`BIT_UNDEF_EN]) begin
        fp_program_status[`BIT_ERR] <= 1'b1;
        last_exc                    <= EXC_UNDEF;
      end else if ((do_load || do_neg) && unpacked.frac[`OVF_POS]
                   && unpacked.exp == 8'hFF) begin
        fp_program_status[1]        <= 1'b1;
        fp_program_status[`BIT_ERR] <= 1'b1;
        last_exc                    <= EXC_OVF;
      end else if (do_load || do_neg) begin
        fp_program_status[3] <= normed.sign;
        fp_program_status[2] <= normed.exp == 8'h00;
        fp_program_status[1] <= 1'b0;
        fp_program_status[0] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exc_irq <= 1'b0;
    end else begin
      exc_irq <= !fp_program_status[`BIT_IRQ_DIS] && (
                 (do_conv && conv_fail && fp_program_status[`BIT_CONV_EN]) ||
                 (do_load && undef_hit && fp_program_status[`BIT_UNDEF_EN]) ||
                 ((do_load || do_neg) && unpacked.frac[`OVF_POS] &&
                  unpacked.exp == 8'hFF && fp_program_status[`BIT_OVER_EN]));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_cond       <= '0;
      cpu_cond_valid <= 1'b0;
    end else begin
      cpu_cond_valid <= copy_cond_codes;
      if (copy_cond_codes) begin
        cpu_cond <= fp_program_status[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      double_precision_sel <= 1'b0;
      long_integer_sel     <= 1'b0;
      truncate_sel         <= 1'b0;
    end else begin
      double_precision_sel <= fp_program_status[`BIT_DOUBLE];
      long_integer_sel     <= fp_program_status[`BIT_LONG];
      truncate_sel         <= fp_program_status[`BIT_TRUNC];
    end
  end

  // The underflow enable is held for the arithmetic core; this block never
  // decrements exponents, so it cannot itself underflow.
  // enable kept
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= 32'h0;
    end else if (rd_en) begin
      case (addr)
        `ADDR_STATUS:    rd_data <= {16'h0, fp_program_status};
        `ADDR_MEM_HI:    rd_data <= mem_word[63:32];
        `ADDR_MEM_LO:    rd_data <= mem_word[31:0];
        `ADDR_RESULT_HI: rd_data <= result_word[63:32];
        `ADDR_RESULT_LO: rd_data <= result_word[31:0];
        `ADDR_EXC:       rd_data <= {29'h0, last_exc};
        default:         rd_data <= 32'h0;
      endcase
    end else begin
      rd_data <= 32'h0;
    end
  end
endmodule : fp_format_and_status
`default_nettype wire

//--- verilog/fp_format_params.svh
`ifndef FP_FORMAT_PARAMS_SVH
`define FP_FORMAT_PARAMS_SVH
`define ADDR_STATUS      4'h0
`define ADDR_MEM_HI      4'h1
`define ADDR_MEM_LO      4'h2
`define ADDR_MEM_CTL     4'h3
`define ADDR_RESULT_HI   4'h4
`define ADDR_RESULT_LO   4'h5
`define ADDR_EXC         4'h6
`define STATUS_RESET     16'h0000
`define STATUS_WMASK     16'hCFEF
`define BIT_ERR          15
`define BIT_IRQ_DIS      14
`define BIT_UNDEF_EN     11
`define BIT_UNDER_EN     10
`define BIT_OVER_EN      9
`define BIT_CONV_EN      8
`define BIT_DOUBLE       7
`define BIT_LONG         6
`define BIT_TRUNC        5
`define EXP_BIAS         8'h80
`define EXP_WIDTH        8
`define SP_FRAC_WIDTH    23
`define DP_FRAC_WIDTH    55
`define OVF_POS          63
`define HIDDEN_POS       62
`define CTL_LOAD         0
`define CTL_NEG          1
`define CTL_STORE        2
`define CTL_CONV         3
`endif

//--- verilog/fp_format_pkg.sv
package fp_format_pkg;
  typedef struct packed {
    logic        sign;
    logic [7:0]  exp;
    logic [63:0] frac;
  } fp_internal_t;
  typedef struct packed {
    logic neg_cond;
    logic zero_cond;
    logic ovf_cond;
    logic carry_cond;
  } cond_codes_t;
  typedef enum logic [2:0] {
    EXC_NONE, EXC_CONV, EXC_OVF, EXC_UNF, EXC_UNDEF
  } exc_t;
endpackage : fp_format_pkg

//--- bench/host_flags_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_flags_model (
  input  wire logic       clk_sys,
  input  wire logic       cpu_cond_valid,
  input  wire logic [3:0] cpu_cond,
  output var  logic [3:0] nzvc
);
  // host flag copy
  // Codes are taken only on the pulse, so stale codes never leak in.
  always_ff @(posedge clk_sys) begin
    if (cpu_cond_valid) nzvc <= cpu_cond;
  end
endmodule : host_flags_model
`default_nettype wire

//--- bench/fp_status_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "fp_format_params.svh"
module fp_status_checker (
  input wire logic                       clk_sys,
  input wire logic                       rst,
  input wire logic [3:0]                 addr,
  input wire logic [31:0]                wr_data,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic                       copy_cond_codes,
  input wire logic [31:0]                rd_data,
  input wire fp_format_pkg::cond_codes_t cpu_cond,
  input wire logic                       cpu_cond_valid,
  input wire logic                       exc_irq,
  input wire logic                       double_precision_sel,
  input wire logic                       long_integer_sel,
  input wire logic                       truncate_sel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       wst;
  logic       dis;
  logic [2:0] md;
  assign wst = wr_en && addr == `ADDR_STATUS;
  assign md = {double_precision_sel, long_integer_sel, truncate_sel};
  // Only software moves the disable bit, so this shadow is exact.
  always_ff @(posedge clk_sys) begin
    if (rst) dis <= 1'b0;
    else if (wst) dis <= wr_data[`BIT_IRQ_DIS];
  end
  ////////////////////////////////////////
  a_unused_bits_zero: assert property (
    $past(rd_en && addr == `ADDR_STATUS) |-> rd_data[31:16] == 16'h0
    && rd_data[13:12] == 2'h0 && !rd_data[4]) else $error("unused set");
  a_mode_follow: assert property (
    wst ##1 !wst |=> md == $past(wr_data[7:5], 2))
    else $error("mode not taken");
  a_mode_hold: assert property (
    !wst && !$past(wst) |=> $stable(md)) else $error("mode moved");
  a_mode_readback: assert property (
    $past(rd_en && addr == `ADDR_STATUS) |-> rd_data[7:5] == md)
    else $error("mode readback");
  a_copy_pulse: assert property (
    cpu_cond_valid == $past(copy_cond_codes)) else $error("copy pulse");
  a_irq_disabled: assert property (
    exc_irq |-> !dis) else $error("irq while disabled");
  a_irq_cause: assert property (
    exc_irq |-> $past(wr_en && addr == `ADDR_MEM_CTL))
    else $error("irq without cause");
  a_unmapped_zero: assert property (
    $past(rd_en && addr > `ADDR_EXC) |-> rd_data == 32'h0)
    else $error("unmapped data");
  c_irq: cover property (exc_irq);
  c_zero: cover property (cpu_cond_valid && cpu_cond.zero_cond);
  c_wr_rd: cover property (wst ##1 rd_en);
endmodule : fp_status_checker
bind fp_format_and_status fp_status_checker chk (.*);
`default_nettype wire

//--- bench/test_fp_format_and_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "fp_format_params.svh"
module test_fp_format_and_status;
  logic        clk_sys, rst, wr_en, rd_en, copy_cond_codes;
  logic [3:0]  addr, nzvc;
  logic [31:0] wr_data, rd_data, v, hi, lo;
  fp_format_pkg::cond_codes_t cpu_cond;
  logic        cpu_cond_valid, exc_irq;
  logic        double_precision_sel, long_integer_sel, truncate_sel;
  int          error_cnt, total_checks, st;
  logic [15:0] nz [3] = '{16'h0880, 16'h4880, 16'h0080};
  fp_format_and_status DUT (.*);
  host_flags_model host (.clk_sys(clk_sys),
    .cpu_cond_valid(cpu_cond_valid), .cpu_cond(cpu_cond), .nzvc(nzvc));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 v = rd_data;
    chk(v, e);
  endtask : rchk
  task automatic ld(input logic [31:0] h, input logic [31:0] l);
    wr(`ADDR_MEM_HI, h);
    wr(`ADDR_MEM_LO, l);
    wr(`ADDR_MEM_CTL, 32'h1);
  endtask : ld
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
  initial begin
    {rst, wr_en, rd_en, copy_cond_codes} = 4'h8;
    addr = 4'h0;
    wr_data = 32'h0;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(32'h07258062));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(`ADDR_STATUS, `STATUS_RESET);
    for (int i = 0; i < 4; i++) begin
      st = $urandom & 32'hFFFF;
      wr(`ADDR_STATUS, st);
      st = st & `STATUS_WMASK;
      rchk(`ADDR_STATUS, st);
      chk({double_precision_sel, long_integer_sel, truncate_sel},
          st[7:5]);
    end
    hi = {1'b0, 8'h81, 23'($urandom)};
    lo = $urandom;
    wr(`ADDR_STATUS, 32'h80);
    ld(hi, lo);
    rchk(`ADDR_RESULT_HI, hi);
    rchk(`ADDR_RESULT_LO, lo);
    wr(`ADDR_MEM_CTL, 32'h2);
    rchk(`ADDR_RESULT_HI, hi ^ 32'h80000000);
    wr(`ADDR_STATUS, 32'h0);
    ld(hi, lo);
    rchk(`ADDR_RESULT_LO, 32'h0);
    foreach (nz[i]) begin
      wr(`ADDR_STATUS, nz[i]);
      ld(32'h80000000, 32'h0);
      chk(exc_irq, nz[i][11] && !nz[i][14]);
    end
    rchk(`ADDR_RESULT_HI, 32'h0);
    ld(32'h007FFFFF, 32'hFFFFFFFF);
    rchk(`ADDR_RESULT_HI, 32'h0);
    @(posedge clk_sys);
    copy_cond_codes <= 1'b1;
    @(posedge clk_sys);
    copy_cond_codes <= 1'b0;
    @(posedge clk_sys);
    #1 chk(nzvc[3:2], 2'b01);
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_STATUS, i ? 32'h1C0 : 32'h180);
      ld(32'h48800000, 32'h0);
      wr(`ADDR_MEM_CTL, 32'h8);
      chk(exc_irq, !i);
    end
    wr(`ADDR_STATUS, 32'h180);
    ld(32'h48800000, 32'h0);
    wr(`ADDR_MEM_CTL, 32'h8);
    rchk(`ADDR_RESULT_HI, 32'h0);
    rchk(`ADDR_EXC, 32'h1);
    rchk(`ADDR_STATUS, 32'h8181);
    wr(`ADDR_STATUS, 32'h0);
    rchk(`ADDR_STATUS, 32'h0);
    conclude();
  end
endmodule : test_fp_format_and_status
`default_nettype wire
